// ===== verilog/icom_top.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module icom_top
  import icom_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire logic [7:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [31:0]          rdata_o,
  // Contact input pins
  input  wire logic [NUM_DI-1:0]    contact_inputs_i,
  // Internal sources
  input  wire logic [NUM_STG-1:0]   stage_sig_i,
  input  wire logic [NUM_LOG-1:0]   logic_out_i,
  input  wire logic                 keypad_release_i,
  input  wire logic                 comm_release_i,
  // Conditioned states
  output logic      [NUM_DI-1:0]    di_status_o,
  output logic      [NUM_VI-1:0]    soft_inputs_o,
  // Events
  output logic      [NUM_DI-1:0]    di_on_event_o,
  output logic      [NUM_DI-1:0]    di_off_event_o,
  output logic      [NUM_VI-1:0]    vi_event_o,
  output logic                      popup_o,
  // Matrix outputs
  output logic      [NUM_RLY-1:0]   relay_o,
  output logic      [NUM_LED-1:0]   led_o,
  output logic      [NUM_VO-1:0]    vout_o,
  output logic                      fault_recorder_trigger_o,
  output logic      [NUM_STG-1:0]   block_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [NUM_DI-1:0]   sync1_reg;
  logic [NUM_DI-1:0]   sync2_reg;
  logic [NUM_DI-1:0]   inv_reg;
  logic [NUM_DI-1:0]   ind_en_reg;
  logic [NUM_DI-1:0]   on_en_reg;
  logic [NUM_DI-1:0]   off_en_reg;
  logic [NUM_VI-1:0]   vi_reg;
  logic [NUM_VI-1:0]   vi_en_reg;
  logic [NUM_TGT-1:0]  latch_reg;
  logic [2:0]          rel_sel_reg;
  logic                rel_wr;
  logic [DLY_W-1:0]    delay_reg [NUM_DI];
  logic [CNT_W-1:0]    count_reg [NUM_DI];
  logic [NUM_SRC-1:0]  omap_reg  [NUM_TGT];
  logic [NUM_SRC-1:0]  bmap_reg  [NUM_STG];
  logic [DLY_W-1:0]    dcnt_reg  [NUM_DI];
  logic [NUM_DI-1:0]   stat_reg;
  logic [NUM_DI-1:0]   on_edge;
  logic [NUM_DI-1:0]   off_edge;
  logic [NUM_VI-1:0]   vi_prev_reg;
  logic [NUM_TGT-1:0]  tgt_reg;
  logic [NUM_SRC-1:0]  src;
  logic [31:0]         tick_reg;
  logic                tick;
  logic                release_now;
  logic [31:0]         rd_next;

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  // Two flops before any logic sees the pins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= contact_inputs_i;
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // 10 ms tick prescaler
  // ---------------------------------------------------------------
  // Shared time base for every delay
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_reg == 32'(TICK_CYCLES - 1)); // R20

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Polarity and event enables per contact input
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      inv_reg    <= '0;
      ind_en_reg <= '0;
      on_en_reg  <= '0;
      off_en_reg <= '0;
    end else if (wr_i) begin
      case (addr_i)
        A_INV:    inv_reg    <= wdata_i[NUM_DI-1:0];
        A_IND_EN: ind_en_reg <= wdata_i[NUM_DI-1:0];
        A_ON_EN:  on_en_reg  <= wdata_i[NUM_DI-1:0];
        A_OFF_EN: off_en_reg <= wdata_i[NUM_DI-1:0];
        default: begin
        end
      endcase
    end
  end

  // Soft input states and their event enables
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vi_reg    <= '0;
      vi_en_reg <= '0;
    end else if (wr_i) begin
      case (addr_i)
        A_VI:    vi_reg    <= wdata_i[NUM_VI-1:0]; // R9
        A_VI_EN: vi_en_reg <= wdata_i[NUM_VI-1:0];
        default: begin
        end
      endcase
    end
  end

  // Latch configuration and release input select
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      latch_reg   <= '0;
      rel_sel_reg <= 3'h0;
    end else if (wr_i) begin
      case (addr_i)
        A_LATCH:   latch_reg   <= wdata_i[NUM_TGT-1:0];
        A_REL_SEL: rel_sel_reg <= wdata_i[2:0];
        default: begin
        end
      endcase
    end
  end
  assign rel_wr = wr_i && (addr_i == A_RELEASE) && wdata_i[0]; // R17

  // Output matrix crossing table
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int t = 0; t < NUM_TGT; t++) omap_reg[t] <= '0;
    end else if (wr_i) begin
      for (int t = 0; t < NUM_TGT; t++) begin
        if (addr_i == A_OMAP + 8'(t)) omap_reg[t] <= wdata_i[NUM_SRC-1:0];
      end
    end
  end

  // Blocking matrix crossing table
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int s = 0; s < NUM_STG; s++) bmap_reg[s] <= '0;
    end else if (wr_i) begin
      for (int s = 0; s < NUM_STG; s++) begin
        if (addr_i == A_BMAP + 8'(s)) bmap_reg[s] <= wdata_i[NUM_SRC-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Contact input conditioning, one slice per input
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_DI; i++) begin : g_di
    logic lvl;
    logic dly_wr;
    logic cnt_wr;
    assign lvl = sync2_reg[i] ^ inv_reg[i]; // R2 R3

    // Write decodes for this input's delay and counter words
    assign dly_wr = wr_i && (addr_i == A_DELAY + 8'(i));
    assign cnt_wr = wr_i && (addr_i == A_COUNT + 8'(i));

    // Delay setting, whole word clamped to 60.00 s
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        delay_reg[i] <= DELAY_RST;
      end else if (dly_wr) begin
        if (wdata_i > 32'(DLY_MAX)) begin
          delay_reg[i] <= DLY_W'(DLY_MAX);
        end else begin
          delay_reg[i] <= wdata_i[DLY_W-1:0];
        end
      end
    end

    // Definite delay on both transitions
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        dcnt_reg[i] <= '0;
        stat_reg[i] <= 1'b0;
      end else if (lvl == stat_reg[i]) begin
        dcnt_reg[i] <= '0;
      end else if (dcnt_reg[i] >= delay_reg[i]) begin
        stat_reg[i] <= lvl; // R4 R1
        dcnt_reg[i] <= '0;
      end else if (tick) begin
        dcnt_reg[i] <= dcnt_reg[i] + DLY_W'(1); // R4 R20
      end
    end

    assign on_edge[i]  = (lvl != stat_reg[i]) && (dcnt_reg[i] >= delay_reg[i]) && lvl;
    assign off_edge[i] = (lvl != stat_reg[i]) && (dcnt_reg[i] >= delay_reg[i]) && !lvl;

    // Active edge counter, an edge in a write cycle adds one to the written value
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        count_reg[i] <= '0;
      end else if (on_edge[i]) begin
        if (cnt_wr) begin
          count_reg[i] <= wdata_i[CNT_W-1:0] + CNT_W'(1); // R5
        end else begin
          count_reg[i] <= count_reg[i] + CNT_W'(1); // R5
        end
      end else if (cnt_wr) begin
        count_reg[i] <= wdata_i[CNT_W-1:0]; // R5
      end
    end
  end

  // ---------------------------------------------------------------
  // Events and pop-up
  // ---------------------------------------------------------------
  // One-cycle event pulses
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      di_on_event_o  <= '0;
      di_off_event_o <= '0;
      vi_event_o     <= '0;
      popup_o        <= 1'b0;
      vi_prev_reg    <= '0;
    end else begin
      di_on_event_o  <= on_edge & on_en_reg;      // R7
      di_off_event_o <= off_edge & off_en_reg;    // R8
      popup_o        <= |(on_edge & ind_en_reg);  // R6
      vi_event_o     <= (vi_reg ^ vi_prev_reg) & vi_en_reg; // R9
      vi_prev_reg    <= vi_reg;
    end
  end

  // ---------------------------------------------------------------
  // Matrix sources and release
  // ---------------------------------------------------------------
  // Inputs, soft inputs, virtual outputs, stages, logic
  assign src = {logic_out_i, stage_sig_i, tgt_reg[TGT_VO +: NUM_VO],
                vi_reg, stat_reg}; // R10 R11 R19

  // Any release source pulses the common release
  always_comb begin
    release_now = rel_wr | keypad_release_i | comm_release_i; // R17
    for (int i = 0; i < NUM_DI; i++) begin
      if (rel_sel_reg == 3'(i + 1) && on_edge[i]) release_now = 1'b1; // R17
    end
  end

  // ---------------------------------------------------------------
  // Output matrix
  // ---------------------------------------------------------------
  for (genvar t = 0; t < NUM_TGT; t++) begin : g_tgt
    logic hit;
    assign hit = |(omap_reg[t] & src); // R12

    // Latched targets hold until release; a live signal beats release
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        tgt_reg[t] <= 1'b0;
      end else if (latch_reg[t]) begin
        tgt_reg[t] <= hit | (tgt_reg[t] & ~release_now); // R15 R16
      end else begin
        tgt_reg[t] <= hit; // R14
      end
    end
  end

  assign relay_o                  = tgt_reg[NUM_RLY-1:0];
  assign led_o                    = tgt_reg[TGT_LED +: NUM_LED]; // R13
  assign vout_o                   = tgt_reg[TGT_VO +: NUM_VO];   // R11
  assign fault_recorder_trigger_o = tgt_reg[TGT_REC];
  assign di_status_o              = stat_reg;
  assign soft_inputs_o            = vi_reg;

  // ---------------------------------------------------------------
  // Blocking matrix
  // ---------------------------------------------------------------
  // Stage inhibited by any configured crossing
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      block_o <= '0;
    end else begin
      for (int s = 0; s < NUM_STG; s++) begin
        block_o[s] <= |(bmap_reg[s] & src); // R18 R19
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read mux, unmapped words read zero
  always_comb begin
    rd_next = ZERO32;
    case (addr_i)
      A_STATUS:  rd_next = 32'({vi_reg, stat_reg});
      A_INV:     rd_next = 32'(inv_reg);
      A_IND_EN:  rd_next = 32'(ind_en_reg);
      A_ON_EN:   rd_next = 32'(on_en_reg);
      A_OFF_EN:  rd_next = 32'(off_en_reg);
      A_VI:      rd_next = 32'(vi_reg);
      A_VI_EN:   rd_next = 32'(vi_en_reg);
      A_LATCH:   rd_next = 32'(latch_reg);
      A_REL_SEL: rd_next = 32'(rel_sel_reg);
      A_OUTS:    rd_next = 32'({block_o, tgt_reg});
      default: begin
        for (int i = 0; i < NUM_DI; i++) begin
          if (addr_i == A_DELAY + 8'(i)) rd_next = 32'(delay_reg[i]);
          if (addr_i == A_COUNT + 8'(i)) rd_next = 32'(count_reg[i]);
        end
        for (int t = 0; t < NUM_TGT; t++) begin
          if (addr_i == A_OMAP + 8'(t)) rd_next = 32'(omap_reg[t]);
        end
        for (int s = 0; s < NUM_STG; s++) begin
          if (addr_i == A_BMAP + 8'(s)) rd_next = 32'(bmap_reg[s]);
        end
      end
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= ZERO32;
    end else if (rd_i) begin
      rdata_o <= rd_next;
    end else begin
      rdata_o <= ZERO32;
    end
  end

endmodule : icom_top
`default_nettype wire

// ===== verilog/icom_pkg.sv
//
// Contract
// R1: Six contact inputs, each giving a conditioned 0/1 status.
// R2: Non-inverted input: active edge is low to high.
// R3: Inverted input: active edge is high to low.
// R4: One delay, 0 to 60 s in 10 ms steps, for both transitions.
// R5: Each input counts active edges, 0 to 65535, counter writable.
// R6: Indication enable makes an active edge raise the pop-up.
// R7: Active-edge event only when the on-event enable is set.
// R8: Inactive-edge event only when the off-event enable is set.
// R9: Four soft inputs, software set, each with its event enable.
// R10: Soft inputs are usable as setting group change sources; the code has no setting group change, soft inputs are only matrix sources.
// R11: Six virtual outputs, output matrix targets and blocking sources.
// R12: Output matrix routes any internal signal to relays, LEDs, outputs, recorder.
// R13: Five LEDs: alarm, trip and three general purpose.
// R14: Non-latched target follows its matrix signal.
// R15: Latched target holds until release.
// R16: One common release clears every latched target.
// R17: Release from a chosen input, keypad, communication or register write.
// R18: Blocking matrix inhibits any stage through any configured crossing.
// R19: Blocking sources include inputs, stage start/trip and logic outputs.
// R20: All conditioning runs on the system clock in 10 ms ticks.
package icom_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_DI    = 6;
  localparam int NUM_VI    = 4;
  localparam int NUM_VO    = 6;
  localparam int NUM_STG   = 8;
  localparam int NUM_LOG   = 8;
  localparam int NUM_RLY   = 4;
  localparam int NUM_LED   = 5;
  localparam int NUM_SRC   = NUM_DI + NUM_VI + NUM_VO + NUM_STG + NUM_LOG;
  localparam int NUM_TGT   = NUM_RLY + NUM_LED + NUM_VO + 1;
  // Target slice positions
  localparam int TGT_LED   = NUM_RLY;
  localparam int TGT_VO    = NUM_RLY + NUM_LED;
  localparam int TGT_REC   = NUM_TGT - 1;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ    = 100_000_000;
  localparam int TICK_MS   = 10;
  localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_MAX   = 6000;   // 60.00 s in ticks
  localparam int DLY_W     = 13;
  localparam int CNT_W     = 16;
  // ---------------------------------------------------------------
  // Register word addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] A_STATUS  = 8'h00;
  localparam logic [7:0] A_INV     = 8'h01;
  localparam logic [7:0] A_IND_EN  = 8'h02;
  localparam logic [7:0] A_ON_EN   = 8'h03;
  localparam logic [7:0] A_OFF_EN  = 8'h04;
  localparam logic [7:0] A_VI      = 8'h05;
  localparam logic [7:0] A_VI_EN   = 8'h06;
  localparam logic [7:0] A_LATCH   = 8'h07;
  localparam logic [7:0] A_RELEASE = 8'h08;
  localparam logic [7:0] A_REL_SEL = 8'h09;
  localparam logic [7:0] A_OUTS    = 8'h0a;
  localparam logic [7:0] A_DELAY   = 8'h10;
  localparam logic [7:0] A_COUNT   = 8'h18;
  localparam logic [7:0] A_OMAP    = 8'h20;
  localparam logic [7:0] A_BMAP    = 8'h30;
  // Reset values
  localparam logic [DLY_W-1:0] DELAY_RST = 13'h0000;
  localparam logic [31:0]      ZERO32    = 32'h0000_0000;
endpackage : icom_pkg

// ===== sim/icom_contacts.sv
`timescale 1ns/1ps
`default_nettype none
module icom_contacts #(
  parameter int SETTLE = 2
) (
  // Clock
  input  wire logic       mclk_i,
  // Contact command and pins
  input  wire logic [5:0] close_i,
  output logic      [5:0] contact_o
);
  logic [5:0] pend_reg  = 6'h00;
  logic [5:0] shown_reg = 6'h00;
  int         age_reg   = 0;

  // Pins keep their old level until the command settles; wetting reads 1 when closed
  always_ff @(posedge mclk_i) begin
    if (close_i != pend_reg) begin
      pend_reg <= close_i;
      age_reg  <= 0;
    end else if (age_reg < SETTLE) begin
      age_reg <= age_reg + 1;
    end else begin
      shown_reg <= pend_reg;
    end
  end
  assign contact_o = shown_reg;
endmodule : icom_contacts
`default_nettype wire

// ===== sim/icom_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module icom_top_chk
  import icom_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  input wire logic [NUM_DI-1:0]   di_status_o,
  input wire logic [NUM_VI-1:0]   soft_inputs_o,
  input wire logic [NUM_DI-1:0]   di_on_event_o,
  input wire logic [NUM_DI-1:0]   di_off_event_o,
  input wire logic [NUM_VI-1:0]   vi_event_o,
  input wire logic                popup_o,
  input wire logic [NUM_RLY-1:0]  relay_o,
  input wire logic [NUM_LED-1:0]  led_o,
  input wire logic [NUM_STG-1:0]  block_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Event pulses
  // ---------------------------------------------------------------
  property p_on_ev;
    (di_on_event_o & ~(di_status_o & ~$past(di_status_o))) == 6'h00;
  endproperty
  a_on_ev: assert property (p_on_ev) else $error("on event without status rise");
  property p_off_ev;
    (di_off_event_o & ~(~di_status_o & $past(di_status_o))) == 6'h00;
  endproperty
  a_off_ev: assert property (p_off_ev) else $error("off event without status fall");
  property p_on_once;
    (di_on_event_o & $past(di_on_event_o)) == 6'h00;
  endproperty
  a_on_once: assert property (p_on_once) else $error("on event longer than a cycle");
  property p_popup;
    popup_o |-> (di_status_o & ~$past(di_status_o)) != 6'h00;
  endproperty
  a_popup: assert property (p_popup) else $error("popup without active edge");
  property p_vi;
    (vi_event_o & ~((soft_inputs_o ^ $past(soft_inputs_o))
      | ($past(soft_inputs_o) ^ $past(soft_inputs_o, 2)))) == 4'h0;
  endproperty
  a_vi: assert property (p_vi) else $error("soft event without change");
  // ---------------------------------------------------------------
  // Register port and reset
  // ---------------------------------------------------------------
  property p_rd_idle;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rst_di;
    $past(rst_i) |-> di_status_o == 6'h00 && di_on_event_o == 6'h00 && !popup_o;
  endproperty
  a_rst_di: assert property (p_rst_di) else $error("inputs not clear after reset");
  property p_rst_mat;
    $past(rst_i) |-> relay_o == 4'h0 && led_o == 5'h00 && block_o == 8'h00;
  endproperty
  a_rst_mat: assert property (p_rst_mat) else $error("matrix not clear after reset");
endmodule : icom_top_chk
bind icom_top icom_top_chk u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .di_status_o(di_status_o), .soft_inputs_o(soft_inputs_o),
  .di_on_event_o(di_on_event_o), .di_off_event_o(di_off_event_o),
  .vi_event_o(vi_event_o), .popup_o(popup_o), .relay_o(relay_o),
  .led_o(led_o), .block_o(block_o));
`default_nettype wire

// ===== sim/icom_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module icom_top_tb
  import icom_pkg::*;
;
  logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, kp = 1'b0, cm = 1'b0;
  logic [7:0]  addr_i = 8'h00, stg = 8'h00, lg = 8'h00, blk;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [5:0]  close_r = 6'h00, pins, st, on_ev, off_ev, vo;
  logic [3:0]  vi, vie, rly, vi_seen = 4'h0;
  logic [4:0]  led;
  logic        pop, frt;
  int          err_total = 0, total_checks = 0;

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) vi_seen <= vi_seen | vie;

  icom_contacts #(.SETTLE(2)) u_contacts (.mclk_i(mclk_i), .close_i(close_r), .contact_o(pins));
  icom_top #(.TICK_CYCLES(4)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .contact_inputs_i(pins), .stage_sig_i(stg),
    .logic_out_i(lg), .keypad_release_i(kp), .comm_release_i(cm), .di_status_o(st),
    .soft_inputs_o(vi), .di_on_event_o(on_ev), .di_off_event_o(off_ev), .vi_event_o(vie),
    .popup_o(pop), .relay_o(rly), .led_o(led), .vout_o(vo),
    .fault_recorder_trigger_o(frt), .block_o(blk));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i) addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i) addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic wst(input int i, input logic v);
    int k;
    k = 0;
    while (st[i] !== v && k < 200) begin
      cyc(1);
      k++;
    end
    chk("di_status", st[i], v);
  endtask : wst
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #200_000;
    err_total++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    cyc(5);
    @(posedge mclk_i) rst_i <= 1'b0;
    rd(A_STATUS);
    chk("status_rst", d, 32'h0);
    rd(8'h0f);
    chk("unmapped", d, 32'h0);
    wr(A_VI_EN, 32'h0000_000f);
    wr(A_VI, 32'h0000_0005);
    cyc(2);
    chk("soft", vi, 4'h5);
    chk("soft_ev", vi_seen, 4'h5);
    rd(A_STATUS);
    chk("status_vi", d, 32'h0000_0140);
    wr(A_OMAP + 8'h01, 32'h0000_0040);
    cyc(3);
    chk("relay1_soft", rly[1], 1'b1);
    wr(A_IND_EN, 32'h1);
    wr(A_ON_EN, 32'h3);
    wr(A_OFF_EN, 32'h2);
    wr(A_INV, 32'h2);
    wst(1, 1'b1);
    @(posedge mclk_i) close_r[0] <= 1'b1;
    wst(0, 1'b1);
    chk("on_ev0", on_ev[0], 1'b1);
    chk("popup0", pop, 1'b1);
    @(posedge mclk_i) close_r[0] <= 1'b0;
    wst(0, 1'b0);
    chk("off_ev0", off_ev[0], 1'b0);
    @(posedge mclk_i) close_r[1] <= 1'b1;
    wst(1, 1'b0);
    chk("off_ev1", off_ev[1], 1'b1);
    @(posedge mclk_i) close_r[1] <= 1'b0;
    wst(1, 1'b1);
    chk("on_ev1", on_ev[1], 1'b1);
    chk("popup1", pop, 1'b0);
    rd(A_COUNT);
    chk("count0", d, 32'h1);
    rd(A_COUNT + 8'h01);
    chk("count1", d, 32'h2);
    wr(A_COUNT, 32'h0000_ffff);
    rd(A_COUNT);
    chk("count_wr", d, 32'h0000_ffff);
    wr(A_DELAY + 8'h03, 32'h0000_ffff);
    rd(A_DELAY + 8'h03);
    chk("dly_clamp", d, 32'h0000_1770);
    wr(A_DELAY + 8'h02, 32'h3);
    @(posedge mclk_i) close_r[2] <= 1'b1;
    cyc(8);
    chk("dly_on_early", st[2], 1'b0);
    wst(2, 1'b1);
    chk("on_ev2_off", on_ev[2], 1'b0);
    @(posedge mclk_i) close_r[2] <= 1'b0;
    cyc(8);
    chk("dly_off_early", st[2], 1'b1);
    wst(2, 1'b0);
    wr(A_OMAP, 32'h0001_0000);
    @(posedge mclk_i) stg[0] <= 1'b1;
    cyc(3);
    chk("relay0_on", rly[0], 1'b1);
    @(posedge mclk_i) stg[0] <= 1'b0;
    cyc(3);
    chk("relay0_off", rly[0], 1'b0);
    wr(A_OMAP + 8'h09, 32'h0004_0000);
    wr(A_BMAP, 32'h0000_0400);
    wr(A_BMAP + 8'h01, 32'h0000_0002);
    wr(A_OMAP + 8'h0f, 32'h0100_0000);
    @(posedge mclk_i) stg[2] <= 1'b1;
    lg[0] <= 1'b1;
    cyc(4);
    chk("vout0", vo, 6'h01);
    chk("block", blk, 8'h03);
    chk("recorder", frt, 1'b1);
    for (int t = 4; t < 9; t++)
      wr(A_OMAP + 8'(t), 32'h0200_0000);
    @(posedge mclk_i) lg[1] <= 1'b1;
    cyc(3);
    chk("leds", led, 5'h1f);
    wr(A_OMAP + 8'h04, 32'h0002_0000);
    wr(A_OMAP + 8'h03, 32'h0002_0000);
    wr(A_LATCH, 32'h0000_0018);
    wr(A_REL_SEL, 32'h1);
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk_i) stg[1] <= 1'b1;
      @(posedge mclk_i) stg[1] <= 1'b0;
      cyc(4);
      chk("held", {rly[3], led[0]}, 2'b11);
      @(posedge mclk_i) kp <= (m == 0);
      cm <= (m == 1);
      @(posedge mclk_i) kp <= 1'b0;
      cm <= 1'b0;
      if (m == 2)
        wr(A_RELEASE, 32'h1);
      if (m == 3) begin
        @(posedge mclk_i) close_r[0] <= 1'b1;
        wst(0, 1'b1);
      end
      cyc(3);
      chk("released", {rly[3], led[0]}, 2'b00);
    end
    end_of_test();
  end
endmodule : icom_top_tb
`default_nettype wire
